// ### ext_pins.sv
`timescale 1ns/1ps
module ext_pins (
	// Device side
	input wire logic [4:0] pinOut,
	input wire logic [4:0] pinOe,
	input wire logic [4:0] pullDownOn,
	input wire logic [4:0] pullUpOn,
	// Outside world
	input wire logic [4:0] strap,
	input wire logic [4:0] strapEn,
	output logic [4:0] level
);
	// Floating pin reads opposite of strap
	always_comb begin
		for (int i = 0; i < 5; i++) level[i] = pinOe[i] ? pinOut[i] :
			strapEn[i] ? strap[i] : pullUpOn[i] ? 1'b1 :
			pullDownOn[i] ? 1'b0 : ~strap[i];
	end
endmodule

// ### gpio_pkg.sv
// Function
// - Five pins, each independently an input or an output.
// - Input pins sampled every clock into the input state register.
// - Sampling can be halted separately per pin.
// - Pins 0 to 2 have individually switchable pull-downs.
// - Pins 3 and 4 have individually switchable pull-ups.
// - After power-on reset all pins are inputs; levels captured.
// - Boot program reads captured start-up states to pick options.
// - Each output pin has an enable; disabled means high impedance.
package gpio_pkg;
	localparam int PIN_COUNT = 5;
	localparam int PULL_DOWN_LO = 0;
	localparam int PULL_DOWN_HI = 2;
	localparam int PULL_UP_LO = 3;
	localparam int PULL_UP_HI = 4;
	localparam logic [4:0] PIN_RESET = 5'h00;
	localparam logic [4:0] DIR_RESET = 5'h00;
	// Cycles the start-up capture waits for the synchroniser
	localparam logic [1:0] BOOT_WAIT = 2'h2;
	localparam int CLK_MHZ = 25;
endpackage

// ### gpio_port.sv
`timescale 1ns/1ps
module gpio_port #(
	parameter int PINS = gpio_pkg::PIN_COUNT
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Configuration
	input wire logic [PINS-1:0] dirOut,
	input wire logic [PINS-1:0] outEnable,
	input wire logic [PINS-1:0] outValue,
	input wire logic [PINS-1:0] freeze,
	input wire logic [PINS-1:0] pullEnable,
	// Pins
	input wire logic [PINS-1:0] pinIn,
	output logic [PINS-1:0] pinOut,
	output logic [PINS-1:0] pinOe,
	output logic [PINS-1:0] pullDownOn,
	output logic [PINS-1:0] pullUpOn,
	// Status
	output logic [PINS-1:0] inputState,
	output logic [PINS-1:0] startupState,
	output logic startupValid
);
	// Pull ranges are fixed to five pins
	if (PINS != gpio_pkg::PIN_COUNT) begin : g_pinCheck
		$error("pin count must be five");
	end

	// Marks the pins that own a given kind of pull switch
	function automatic logic [PINS-1:0] pullMask(input int lo,
		input int hi);
		logic [PINS-1:0] mask;
		mask = '0;
		for (int i = 0; i < PINS; i++) begin
			if (i >= lo && i <= hi)
				mask[i] = 1'b1;
		end
		return mask;
	endfunction

	localparam logic [PINS-1:0] PD_MASK =
		pullMask(gpio_pkg::PULL_DOWN_LO, gpio_pkg::PULL_DOWN_HI);
	localparam logic [PINS-1:0] PU_MASK =
		pullMask(gpio_pkg::PULL_UP_LO, gpio_pkg::PULL_UP_HI);

	// Two-stage synchroniser
	logic [PINS-1:0] syncA_r;
	logic [PINS-1:0] syncA_nxt;
	logic [PINS-1:0] syncB_r;
	logic [PINS-1:0] syncB_nxt;
	// Sampled input state
	logic [PINS-1:0] inState_r;
	logic [PINS-1:0] inState_nxt;
	// Start-up capture
	logic [PINS-1:0] boot_r;
	logic [PINS-1:0] boot_nxt;
	logic [1:0] bootCnt_r;
	logic [1:0] bootCnt_nxt;
	logic bootDone_r;
	logic bootDone_nxt;
	// Output drive
	logic [PINS-1:0] out_r;
	logic [PINS-1:0] out_nxt;
	logic [PINS-1:0] oe_r;
	logic [PINS-1:0] oe_nxt;
	// Pull switches
	logic [PINS-1:0] pd_r;
	logic [PINS-1:0] pd_nxt;
	logic [PINS-1:0] pu_r;
	logic [PINS-1:0] pu_nxt;

	always_comb begin
		syncA_nxt = pinIn;
		syncB_nxt = syncA_r;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA_r <= gpio_pkg::PIN_RESET;
			syncB_r <= gpio_pkg::PIN_RESET;
		end else begin
			syncA_r <= syncA_nxt;
			syncB_r <= syncB_nxt;
		end
	end

	// Halted or output pins keep their last sampled value
	always_comb begin
		inState_nxt = inState_r;
		for (int i = 0; i < PINS; i++) begin
			if (!freeze[i] && !dirOut[i])
				inState_nxt[i] = syncB_r[i];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			inState_r <= gpio_pkg::PIN_RESET;
		end else begin
			inState_r <= inState_nxt;
		end
	end

	// Capture waits for the synchroniser to fill
	always_comb begin
		boot_nxt = boot_r;
		bootCnt_nxt = bootCnt_r;
		bootDone_nxt = bootDone_r;
		if (!bootDone_r) begin
			if (bootCnt_r == gpio_pkg::BOOT_WAIT) begin
				boot_nxt = syncB_r;
				bootDone_nxt = 1'b1;
			end else begin
				bootCnt_nxt = bootCnt_r + 2'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_r <= gpio_pkg::PIN_RESET;
			bootCnt_r <= 2'h0;
			bootDone_r <= 1'b0;
		end else begin
			boot_r <= boot_nxt;
			bootCnt_r <= bootCnt_nxt;
			bootDone_r <= bootDone_nxt;
		end
	end

	// Pins stay inputs until the start-up capture is done
	always_comb begin
		out_nxt = outValue;
		oe_nxt = gpio_pkg::DIR_RESET;
		if (bootDone_r)
			oe_nxt = dirOut & outEnable;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_r <= gpio_pkg::PIN_RESET;
			oe_r <= gpio_pkg::DIR_RESET;
		end else begin
			out_r <= out_nxt;
			oe_r <= oe_nxt;
		end
	end

	always_comb begin
		pd_nxt = pullEnable & PD_MASK;
		pu_nxt = pullEnable & PU_MASK;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pd_r <= gpio_pkg::PIN_RESET;
			pu_r <= gpio_pkg::PIN_RESET;
		end else begin
			pd_r <= pd_nxt;
			pu_r <= pu_nxt;
		end
	end

	assign inputState = inState_r;
	assign startupState = boot_r;
	assign startupValid = bootDone_r;
	assign pinOut = out_r;
	assign pinOe = oe_r;
	assign pullDownOn = pd_r;
	assign pullUpOn = pu_r;

	sample_follow_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		!freeze[0] && !dirOut[0] |=> inputState[0] == $past(syncB_r[0]))
		else $error("input pin 0 not sampled");
	freeze_hold_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		freeze[1] |=> $stable(inputState[1]))
		else $error("frozen pin 1 changed");
	freeze_last_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		freeze[2] [*3] |-> $stable(inputState[2]))
		else $error("frozen pin 2 lost its value");
	pull_down_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		1'b1 |=> pullDownOn[4:3] == 2'h0 &&
		pullDownOn[2:0] == $past(pullEnable[2:0]))
		else $error("pull-down wrong");
	pull_up_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		1'b1 |=> pullUpOn[2:0] == 3'h0 &&
		pullUpOn[4:3] == $past(pullEnable[4:3]))
		else $error("pull-up wrong");
	boot_input_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		!startupValid |=> pinOe == 5'h00)
		else $error("pin driven before start-up capture");
	boot_once_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		startupValid |=> startupValid && $stable(startupState))
		else $error("start-up register changed");
	boot_load_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		$rose(startupValid) |-> startupState == $past(syncB_r))
		else $error("start-up capture wrong");
	drive_enable_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		startupValid && dirOut[4] && !outEnable[4] |=> !pinOe[4])
		else $error("disabled output driven");
	out_dir_a: assert property (@(posedge ref_clk)
		disable iff (!rst_n)
		startupValid && dirOut[0] && outEnable[0] |=>
		pinOe[0] && pinOut[0] == $past(outValue[0]))
		else $error("output pin 0 not driven");

	// Sample, hold, high-impedance and drive checks repeated on every pin
	for (genvar g = 0; g < PINS; g++) begin : g_pinProps
		pin_follow_a: assert property (@(posedge ref_clk)
			disable iff (!rst_n)
			!freeze[g] && !dirOut[g] |=>
			inputState[g] == $past(syncB_r[g]))
			else $error("input pin not sampled");
		pin_hold_a: assert property (@(posedge ref_clk)
			disable iff (!rst_n)
			freeze[g] || dirOut[g] |=> $stable(inputState[g]))
			else $error("halted pin changed");
		pin_hiz_a: assert property (@(posedge ref_clk)
			disable iff (!rst_n)
			!(dirOut[g] && outEnable[g]) |=> !pinOe[g])
			else $error("pin driven while disabled");
		pin_drive_a: assert property (@(posedge ref_clk)
			disable iff (!rst_n)
			startupValid && dirOut[g] && outEnable[g] |=>
			pinOe[g] && pinOut[g] == $past(outValue[g]))
			else $error("output pin not driven");
	end

	startup_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(startupValid));
	freeze_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
		freeze[0] && $changed(syncB_r[0]));
	drive_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
		pinOe == 5'h0F);
	hiz_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
		startupValid && dirOut[4] && !outEnable[4]);
	pull_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
		pullUpOn == 5'h18 && pullDownOn == 5'h07);
endmodule

// ### gpio_port_with_boot_strap_test.sv
`timescale 1ns/1ps
module gpio_port_with_boot_strap_test;
	logic ref_clk = 1'b0, rst_n = 1'b0, startupValid;
	logic [4:0] dirOut = 5'h00, outEnable = 5'h00, outValue = 5'h00;
	logic [4:0] freeze = 5'h00, pullEnable = 5'h00;
	logic [4:0] strap = 5'h15, strapEn = 5'h1F, level, pinOut, pinOe;
	logic [4:0] pullDownOn, pullUpOn, inputState, startupState;
	int num_errors = 0, cmp_count = 0;
	always #20 ref_clk = ~ref_clk;
	gpio_port DUT (.ref_clk, .rst_n, .dirOut, .outEnable, .outValue, .freeze,
		.pullEnable, .pinIn(level), .pinOut, .pinOe, .pullDownOn, .pullUpOn,
		.inputState, .startupState, .startupValid);
	ext_pins model (.pinOut, .pinOe, .pullDownOn, .pullUpOn, .strap,
		.strapEn, .level);
	task automatic check(input logic [5:0] seen, input logic [5:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic results;
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic startup_test;
		check({startupValid, startupState}, 6'h00);
		rst_n = 1'b1;
		tick(4);
		check({startupValid, startupState}, 6'h35);
		check({1'b0, pinOe}, 6'h00);
		strap = 5'h0A;
		tick(5);
		check({1'b0, startupState}, 6'h15);
		check({1'b0, inputState}, 6'h0A);
		$display("startup test done");
	endtask
	task automatic freeze_test;
		freeze = 5'h07;
		strap = 5'h15;
		tick(5);
		check({1'b0, inputState}, 6'h12);
		tick(3);
		check({1'b0, inputState}, 6'h12);
		freeze = 5'h00;
		tick(5);
		check({1'b0, inputState}, 6'h15);
		$display("freeze test done");
	endtask
	task automatic pin_test;
		strapEn = 5'h00;
		dirOut = 5'h1F;
		outEnable = 5'h0F;
		outValue = 5'h05;
		tick(3);
		check({1'b0, pinOe}, 6'h0F);
		check({1'b0, pinOut & pinOe}, 6'h05);
		check({1'b0, inputState}, 6'h15);
		dirOut = 5'h00;
		pullEnable = 5'h1F;
		tick(6);
		check({1'b0, pullDownOn}, 6'h07);
		check({1'b0, pullUpOn}, 6'h18);
		check({1'b0, inputState}, 6'h18);
		$display("pin test done");
	endtask
	task automatic reset_test;
		rst_n = 1'b0;
		strapEn = 5'h1F;
		strap = 5'h0C;
		tick(1);
		check({startupValid, startupState}, 6'h00);
		check({1'b0, pullUpOn}, 6'h00);
		tick(1);
		rst_n = 1'b1;
		tick(4);
		check({startupValid, startupState}, 6'h2C);
		check({1'b0, pinOe}, 6'h00);
		check({1'b0, inputState}, 6'h0C);
		$display("reset test done");
	endtask
	initial begin
		tick(6);
		startup_test;
		freeze_test;
		pin_test;
		reset_test;
		results;
	end
	initial begin
		#(2000 * 40);
		num_errors++;
		results;
	end
endmodule
